/* rsc_ctrl.sv */
// main radio state controller
//
// Functional notes
// - state moves only on strobes or events
// - output zero defaults to clock divided 192
// - serial output low reports power-up done
// - output high until crystal stable, then low
// - reset strobe restores defaults, enters idle
// - crystal automatic unless force-on bit set
// - crystal-off/power-down only from idle, on release
// - select fall restarts crystal, enters idle
// - force-on keeps crystal running in sleep
// - regulator off in sleep, back on select
// - receive and transmit strobes enter rx/tx
// - manual and three automatic calibration options
// - idle strobe skips calibration; fixed length
// - rx ends on packet/timeout, goes to field
// - stay-in-rx after packet delays rssi valid
// - tx ends after packet, goes to field
// - receive strobe in tx switches to rx
// - tx/synth strobe in rx needs clear channel
// - refused transmit never retried automatically
// - four clear channel conditions selectable
// - idle strobe forces idle from anywhere
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl #(
	parameter int CAL_CYCLES  = rsc_pkg::CAL_XOSC_CYCLES, // calibration length
	parameter int RSSI_SETTLE = rsc_pkg::RSSI_CYCLES      // rssi settle length
) (
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               cs_n_pin,
	input  wire logic               crystal_stable,
	input  wire logic               reset_strobe,
	input  wire logic               idle_strobe,
	input  wire logic               receive_strobe,
	input  wire logic               transmit_strobe,
	input  wire logic               synth_on_strobe,
	input  wire logic               calibrate_strobe,
	input  wire logic               crystal_off_strobe,
	input  wire logic               power_down_strobe,
	input  wire logic               crystal_force_on,
	input  wire logic [1:0]         auto_calibration_select,
	input  wire logic [1:0]         after_receive_state,
	input  wire logic [1:0]         after_transmit_state,
	input  wire logic [1:0]         clear_channel_mode,
	input  wire logic               general_output_select,
	input  wire logic               general_output_alt,
	input  wire logic               packet_received,
	input  wire logic               rx_timeout,
	input  wire logic               packet_sent,
	input  wire logic               tx_underflow,
	input  wire logic               rssi_below_threshold,
	input  wire logic               receiving_packet,
	output var  rsc_pkg::rsc_state_t radio_state,
	output var  logic               chip_ready_low,
	output var  logic               crystal_enable,
	output var  logic               regulator_enable,
	output var  logic               calibrating,
	output var  logic               rssi_valid,
	output var  logic               general_output_zero
);
	import rsc_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic       cs_n_s;        // synchronised chip select
	logic       xtal_ok_s;     // synchronised crystal stable
	logic       cs_n_d;        // chip select one cycle late
	logic       cs_fall;       // chip select went low
	logic       cs_rise;       // chip select released
	logic       cca_ok;        // channel counts as clear
	logic       reset_strobe_busy;     // soft reset still running
	logic       cal_done;      // last calibration cycle
	logic       rssi_busy;     // rssi settling
	logic       rssi_start;    // start rssi settle window
	logic       cal_start;     // start calibration timer
	logic       auto_ret;      // automatic return to idle
	logic       cal_on_ret;    // calibrate on this return
	logic       pd_sleep;      // power-down strobe pending
	logic       pd_crystal_off_state;       // crystal-off strobe pending
	logic [1:0] auto_cnt;      // automatic return counter
	logic [6:0] div_cnt;       // clock out divider
	logic       div_clk;       // divided clock
	rsc_state_t cal_ret;       // state after calibration
	rsc_state_t next_state;    // next controller state
	rsc_state_t next_cal_ret;  // next return state

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	rsc_sync #(.W(2), .RST(2'h1)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({crystal_stable, cs_n_pin}),
		.q      ({xtal_ok_s, cs_n_s})
	);

	// chip select edge detect on the synchronised level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cs_n_d <= 1'b1;
		end else begin
			cs_n_d <= cs_n_s;
		end
	end

	assign cs_fall = cs_n_d && !cs_n_s;
	assign cs_rise = !cs_n_d && cs_n_s;

	// ------------------------------------------------------------
	// timers
	// ------------------------------------------------------------
	// soft reset busy window after the reset strobe
	rsc_timer #(.W(TMR_W)) u_reset_strobe (
		.clk    (clk),
		.resetn (resetn),
		.clear  (1'b0),
		.start  (reset_strobe),
		.load   (TMR_W'(RESET_STROBE_CYCLES)),
		.busy   (reset_strobe_busy),
		.done   ()
	);

	// calibration length, aborted by idle or reset strobe
	rsc_timer #(.W(TMR_W)) u_cal (
		.clk    (clk),
		.resetn (resetn),
		.clear  (reset_strobe || idle_strobe),
		.start  (cal_start),
		.load   (TMR_W'(CAL_CYCLES)),
		.busy   (),
		.done   (cal_done)
	);

	// rssi settle window when staying in rx
	rsc_timer #(.W(TMR_W)) u_rssi (
		.clk    (clk),
		.resetn (resetn),
		.clear  (reset_strobe),
		.start  (rssi_start),
		.load   (TMR_W'(RSSI_SETTLE)),
		.busy   (rssi_busy),
		.done   ()
	);

	// ------------------------------------------------------------
	// clear channel assessment
	// ------------------------------------------------------------
	always_comb begin
		case (clear_channel_mode)
			CCA_ALWAYS: cca_ok = 1'b1;
			CCA_RSSI:   cca_ok = rssi_below_threshold;
			CCA_NOPKT:  cca_ok = !receiving_packet;
			CCA_BOTH:   cca_ok = rssi_below_threshold && !receiving_packet;
			default:    cca_ok = 1'b0;
		endcase
	end

	// map a destination field to a state
	function automatic rsc_state_t dest_state(input logic [1:0] d);
		case (d)
			DEST_SYNTH: dest_state = st_synth;
			DEST_TX:    dest_state = st_tx;
			DEST_RX:    dest_state = st_rx;
			default:    dest_state = st_idle;
		endcase
	endfunction : dest_state

	// calibration due on an automatic return to idle
	assign cal_on_ret = (auto_calibration_select == CAL_TO_IDLE) ||
		(auto_calibration_select == CAL_EVERY4 && auto_cnt == 2'h3);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		rsc_state_t tgt; // requested destination
		tgt          = st_idle;
		next_state   = radio_state;
		next_cal_ret = cal_ret;
		cal_start    = 1'b0;
		auto_ret     = 1'b0;
		rssi_start   = 1'b0;
		case (radio_state)
			// idle: strobes start rx, tx, synth or calibration
			st_idle: begin
				if (receive_strobe) begin
					tgt = st_rx;
				end else if (transmit_strobe) begin
					tgt = st_tx;
				end else if (synth_on_strobe) begin
					tgt = st_synth;
				end
				if (tgt == st_idle && calibrate_strobe) begin
					next_state   = st_cal;
					next_cal_ret = st_idle;
					cal_start    = 1'b1;
				end else if (tgt != st_idle && auto_calibration_select == CAL_FROM_IDLE) begin
					next_state   = st_cal;
					next_cal_ret = tgt;
					cal_start    = 1'b1;
				end else if (tgt != st_idle) begin
					next_state = tgt;
				end else if (cs_rise && pd_sleep) begin
					next_state = st_sleep;
				end else if (cs_rise && pd_crystal_off_state) begin
					next_state = st_crystal_off_state;
				end
			end
			// low power: select fall restores idle
			st_sleep, st_crystal_off_state: begin
				if (cs_fall) begin
					next_state = st_idle;
				end
			end
			// calibration runs a fixed count
			st_cal: begin
				if (cal_done) begin
					next_state = cal_ret;
				end
			end
			// synth ready: go on to tx or rx
			st_synth: begin
				if (transmit_strobe) begin
					next_state = st_tx;
				end else if (receive_strobe) begin
					next_state = st_rx;
				end
			end
			// receive: strobes gated by clear channel, else events
			st_rx: begin
				if (transmit_strobe && cca_ok) begin
					next_state = st_tx;
				end else if (synth_on_strobe && cca_ok) begin
					next_state = st_synth;
				end else if (packet_received || rx_timeout) begin
					tgt = dest_state(after_receive_state);
					if (tgt == st_rx && packet_received) begin
						rssi_start = 1'b1;
					end
					auto_ret = (tgt == st_idle);
					if (tgt == st_idle && cal_on_ret) begin
						next_state   = st_cal;
						next_cal_ret = st_idle;
						cal_start    = 1'b1;
					end else begin
						next_state = tgt;
					end
				end
			end
			// transmit: rx strobe switches, events end the packet
			st_tx: begin
				if (receive_strobe) begin
					next_state = st_rx;
				end else if (tx_underflow) begin
					next_state = st_idle;
				end else if (packet_sent) begin
					tgt      = dest_state(after_transmit_state);
					auto_ret = (tgt == st_idle);
					if (tgt == st_idle && cal_on_ret) begin
						next_state   = st_cal;
						next_cal_ret = st_idle;
						cal_start    = 1'b1;
					end else begin
						next_state = tgt;
					end
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
		// idle strobe overrides everything and never calibrates
		if (idle_strobe || reset_strobe) begin
			next_state = st_idle;
			cal_start  = 1'b0;
			auto_ret   = 1'b0;
			rssi_start = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	// state changes only through next_state above
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			radio_state <= st_idle;
			cal_ret     <= st_idle;
		end else begin
			radio_state <= next_state;
			cal_ret     <= next_cal_ret;
		end
	end

	// counts automatic returns for every-fourth calibration
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			auto_cnt <= AUTO_CNT_RST;
		end else if (reset_strobe) begin
			auto_cnt <= AUTO_CNT_RST;
		end else if (auto_ret && auto_calibration_select == CAL_EVERY4) begin
			auto_cnt <= auto_cnt + 2'h1;
		end
	end

	// power-down and crystal-off wait for select release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pd_sleep <= 1'b0;
			pd_crystal_off_state  <= 1'b0;
		end else if (reset_strobe || idle_strobe || radio_state != st_idle) begin
			pd_sleep <= 1'b0;
			pd_crystal_off_state  <= 1'b0;
		end else begin
			if (power_down_strobe) begin
				pd_sleep <= 1'b1;
			end
			if (crystal_off_strobe && !crystal_force_on) begin
				pd_crystal_off_state <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// power and status outputs
	// ------------------------------------------------------------
	// crystal off only in low power states, unless forced
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			crystal_enable   <= 1'b1;
			regulator_enable <= 1'b1;
		end else begin
			crystal_enable   <= crystal_force_on ||
				!(radio_state == st_sleep || radio_state == st_crystal_off_state);
			regulator_enable <= (radio_state != st_sleep);
		end
	end

	// ready low only with select low, crystal stable, no soft reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chip_ready_low <= 1'b1;
		end else begin
			chip_ready_low <= cs_n_s || !xtal_ok_s || reset_strobe_busy || !crystal_enable;
		end
	end

	// calibration and rssi status
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			calibrating <= 1'b0;
			rssi_valid  <= 1'b0;
		end else begin
			calibrating <= (radio_state == st_cal);
			rssi_valid  <= (radio_state == st_rx) && !rssi_busy && !rssi_start;
		end
	end

	// ------------------------------------------------------------
	// general output zero
	// ------------------------------------------------------------
	// divide by 192: toggle every half period
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt <= 7'h00;
			div_clk <= 1'b0;
		end else if (div_cnt == GDO_HALF_M1) begin
			div_cnt <= 7'h00;
			div_clk <= !div_clk;
		end else begin
			div_cnt <= div_cnt + 7'h01;
		end
	end

	// divided clock unless another function selected
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			general_output_zero <= 1'b0;
		end else begin
			general_output_zero <= general_output_select ? general_output_alt : div_clk;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// strobe without competing strobes
	sequence s_rx_in_tx;
		radio_state == st_tx && receive_strobe && !idle_strobe && !reset_strobe;
	endsequence
	sequence s_cal_entry;
		radio_state == st_idle && receive_strobe && !idle_strobe && !reset_strobe &&
			auto_calibration_select == CAL_FROM_IDLE;
	endsequence
	sequence s_refused_tx;
		radio_state == st_rx && transmit_strobe && !cca_ok && !idle_strobe &&
			!reset_strobe && !synth_on_strobe && !packet_received && !rx_timeout;
	endsequence

	a_idle_any_state: assert property (idle_strobe |=> radio_state == st_idle)
		else $error("idle strobe did not reach idle");
	a_rx_from_tx: assert property (s_rx_in_tx |=> radio_state == st_rx)
		else $error("receive strobe in tx did not enter rx");
	a_autocal_entry: assert property (s_cal_entry |=> radio_state == st_cal ##1 calibrating [*2])
		else $error("no calibration on leaving idle");
	a_cca_refuse: assert property (s_refused_tx |=> radio_state == st_rx)
		else $error("busy channel let controller leave rx");
	a_no_auto_tx: assert property (radio_state == st_rx && !transmit_strobe && !synth_on_strobe &&
		!packet_received && !rx_timeout |=> !(radio_state == st_tx || radio_state == st_synth))
		else $error("tx entered without a strobe");
	a_idle_no_cal: assert property (radio_state == st_rx && idle_strobe
		|=> radio_state == st_idle ##1 !calibrating)
		else $error("idle strobe caused calibration");
	a_sleep_reg_off: assert property (radio_state == st_sleep ##1 radio_state == st_sleep
		|-> !regulator_enable)
		else $error("regulator on in sleep");
	a_force_crystal: assert property (crystal_force_on |=> crystal_enable)
		else $error("forced crystal turned off");
	a_ready_unstable: assert property (!xtal_ok_s |=> chip_ready_low)
		else $error("ready shown before crystal stable");
	a_rssi_hold: assert property (radio_state == st_rx && packet_received &&
		after_receive_state == DEST_RX && !idle_strobe && !reset_strobe &&
		!transmit_strobe && !synth_on_strobe |=> !rssi_valid [*2])
		else $error("rssi valid too soon after packet");
	a_gdo_divider: assert property ((!general_output_select) [*2] ##0 $changed(general_output_zero)
		|=> ($stable(general_output_zero) || general_output_select) [*8])
		else $error("clock output toggled too early");
endmodule : rsc_ctrl
`default_nettype wire

/* rsc_ctrl_tb_top.sv */
// self-checking bench of the radio state controller
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl_tb_top;
	import rsc_pkg::*;
	localparam int RST = 0, IDL = 1, RXS = 2, TXS = 3, SYN = 4, CAL = 5, XOF = 6, PWD = 7;
	logic clk = 1'h0, resetn = 1'h0, crystal_stable = 1'h0, crystal_force_on = 1'h0; // clock and levels
	logic general_output_select = 1'h0, general_output_alt = 1'h0; // output zero control
	logic packet_received = 1'h0, rx_timeout = 1'h0, packet_sent = 1'h0, tx_underflow = 1'h0; // events
	logic rssi_below_threshold = 1'h1, receiving_packet = 1'h0; // channel levels
	logic [1:0] auto_calibration_select = 2'h0, after_receive_state = 2'h0; // mode fields
	logic [1:0] after_transmit_state = 2'h0, clear_channel_mode = 2'h0; // mode fields
	logic cs_n_pin, chip_ready_low, crystal_enable, regulator_enable, calibrating, rssi_valid;
	logic general_output_zero, w, clr, alt; // output zero and scratch
	logic [7:0] stb; // host strobes
	rsc_state_t radio_state; // controller state
	rsc_state_t dst [4] = '{st_idle, st_synth, st_tx, st_rx}; // state per destination code
	int failures = 0, checks = 0, n; // tallies
	// 10 MHz clock
	initial forever #50 clk = ~clk;
	rsc_host rsc_host_inst (.clk, .chip_ready_low, .cs_n_pin, .strobes(stb));
	rsc_ctrl #(.CAL_CYCLES(8), .RSSI_SETTLE(4)) rsc_ctrl_inst (.clk, .resetn, .cs_n_pin, .crystal_stable,
		.reset_strobe(stb[RST]), .idle_strobe(stb[IDL]), .receive_strobe(stb[RXS]), .transmit_strobe(stb[TXS]),
		.synth_on_strobe(stb[SYN]), .calibrate_strobe(stb[CAL]), .crystal_off_strobe(stb[XOF]),
		.power_down_strobe(stb[PWD]), .crystal_force_on, .auto_calibration_select, .after_receive_state,
		.after_transmit_state, .clear_channel_mode, .general_output_select, .general_output_alt,
		.packet_received, .rx_timeout, .packet_sent, .tx_underflow, .rssi_below_threshold,
		.receiving_packet, .radio_state, .chip_ready_low, .crystal_enable, .regulator_enable,
		.calibrating, .rssi_valid, .general_output_zero);
	// verdict and end of run
	task automatic test_done();
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	// one comparison
	task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	task automatic ck(input rsc_state_t e);
		chk("radio_state", e, radio_state);
	endtask : ck
	task automatic str(input int i);
		rsc_host_inst.pulse(i);
	endtask : str
	// one-cycle event pulse from the current falling edge: 0 rx packet, 1 rx timeout, 2 tx packet, 3 underflow
	task automatic ev(input int i);
		packet_received = (i == 0);
		rx_timeout = (i == 1);
		packet_sent = (i == 2);
		tx_underflow = (i == 3);
		cyc(1);
		{packet_received, rx_timeout, packet_sent, tx_underflow} = 4'h0;
	endtask : ev
	// bounded wait for a state; a miss ends the run
	task automatic wst(input rsc_state_t e);
		n = 0;
		while (radio_state !== e && n < 20) begin
			cyc(1);
			n++;
		end
		ck(e);
		if (radio_state !== e)
			test_done();
	endtask : wst
	// length of a calibration, then where it leads
	task automatic calrun(input rsc_state_t e);
		n = 0;
		while (radio_state === st_cal && n < 50) begin
			cyc(1);
			n++;
		end
		chk("cal cycles", 7'h08, 7'(n));
		chk("calibrating", 7'h01, calibrating);
		ck(e);
	endtask : calrun
	// watchdog
	initial begin
		#6000000;
		failures++;
		test_done();
	end
	// main sequence
	initial begin
		cyc(3);
		resetn = 1'h1;
		ck(st_idle);
		chk("crystal_enable", 7'h01, crystal_enable);
		fork
			rsc_host_inst.power_up();
			begin
				cyc(6);
				chk("chip_ready_low", 7'h01, chip_ready_low);
				crystal_stable = 1'h1;
			end
		join
		chk("chip_ready_low", 7'h00, chip_ready_low);
		chk("host waits", 7'h00, 7'(rsc_host_inst.err));
		ck(st_idle);
		for (int k = 0; k < 2; k++) begin
			w = general_output_zero;
			n = 0;
			while (general_output_zero === w && n < 200) begin
				cyc(1);
				n++;
			end
		end
		chk("output zero half period", 7'd96, 7'(n));
		general_output_select = 1'h1;
		general_output_alt = 1'h1;
		cyc(4);
		chk("general_output_zero", 7'h01, general_output_zero);
		for (int d = 0; d < 4; d++) begin
			after_receive_state = 2'(d);
			after_transmit_state = 2'(d);
			str(RXS);
			ck(st_rx);
			ev(d[0] ? 1 : 0);
			ck(dst[d]);
			str(IDL);
			ck(st_idle);
			str(TXS);
			ck(st_tx);
			ev(2);
			ck(dst[d]);
			str(IDL);
			ck(st_idle);
		end
		str(RXS);
		cyc(8);
		chk("rssi_valid", 7'h01, rssi_valid);
		ev(0);
		n = 0;
		repeat (10) begin
			n += int'(!rssi_valid);
			cyc(1);
		end
		chk("rssi gap seen", 7'h01, 7'(n > 0));
		chk("rssi_valid", 7'h01, rssi_valid);
		str(TXS);
		str(RXS);
		ck(st_rx);
		str(TXS);
		ev(3);
		ck(st_idle);
		for (int c = 0; c < 16; c++) begin
			clear_channel_mode = 2'(c >> 2);
			rssi_below_threshold = c[1];
			receiving_packet = c[0];
			alt = c[0] ^ c[1];
			clr = (c < 4) || (c >> 2 == 1 && c[1]) || (c >> 2 == 2 && !c[0]) || (c >> 2 == 3 && c[1] && !c[0]);
			str(RXS);
			str(alt ? SYN : TXS);
			ck(clr ? (alt ? st_synth : st_tx) : st_rx);
			if (!clr) begin
				rssi_below_threshold = 1'h1;
				receiving_packet = 1'h0;
				cyc(4);
				ck(st_rx);
			end
			str(IDL);
		end
		after_receive_state = 2'h0;
		after_transmit_state = 2'h0;
		auto_calibration_select = 2'h1;
		str(RXS);
		calrun(st_rx);
		str(IDL);
		auto_calibration_select = 2'h2;
		str(RXS);
		str(IDL);
		ck(st_idle);
		str(RXS);
		ev(0);
		calrun(st_idle);
		auto_calibration_select = 2'h3;
		str(RXS);
		str(RST);
		ck(st_idle);
		rsc_host_inst.wait_ready(1'h1);
		rsc_host_inst.wait_ready(1'h0);
		for (int i = 0; i < 4; i++) begin
			str(i[0] ? TXS : RXS);
			ev(i[0] ? 2 : 0);
			if (i == 3)
				calrun(st_idle);
			else
				ck(st_idle);
		end
		auto_calibration_select = 2'h0;
		str(CAL);
		calrun(st_idle);
		str(PWD);
		rsc_host_inst.sel(1'h1);
		wst(st_sleep);
		cyc(2);
		chk("crystal_enable", 7'h00, crystal_enable);
		chk("regulator_enable", 7'h00, regulator_enable);
		rsc_host_inst.sel(1'h0);
		ck(st_idle);
		chk("regulator_enable", 7'h01, regulator_enable);
		chk("crystal_enable", 7'h01, crystal_enable);
		str(XOF);
		rsc_host_inst.sel(1'h1);
		wst(st_crystal_off_state);
		cyc(2);
		chk("crystal_enable", 7'h00, crystal_enable);
		rsc_host_inst.sel(1'h0);
		ck(st_idle);
		crystal_force_on = 1'h1;
		str(PWD);
		rsc_host_inst.sel(1'h1);
		wst(st_sleep);
		cyc(2);
		chk("crystal_enable", 7'h01, crystal_enable);
		rsc_host_inst.sel(1'h0);
		str(XOF);
		rsc_host_inst.sel(1'h1);
		cyc(6);
		ck(st_idle);
		rsc_host_inst.sel(1'h0);
		crystal_force_on = 1'h0;
		str(RXS);
		str(PWD);
		str(CAL);
		ck(st_rx);
		general_output_alt = 1'h0;
		cyc(2);
		chk("general_output_zero", 7'h00, general_output_zero);
		crystal_stable = 1'h0;
		cyc(4);
		chk("chip_ready_low", 7'h01, chip_ready_low);
		crystal_stable = 1'h1;
		resetn = 1'h0;
		cyc(2);
		ck(st_idle);
		resetn = 1'h1;
		rsc_host_inst.wait_ready(1'h0);
		chk("crystal_enable", 7'h01, crystal_enable);
		chk("host waits", 7'h00, 7'(rsc_host_inst.err));
		test_done();
	end
endmodule : rsc_ctrl_tb_top
`default_nettype wire

/* rsc_host.sv */
// host model: chip select and command strobes
`timescale 1ns/1ps
`default_nettype none
module rsc_host (
	input  wire logic       clk,
	input  wire logic       chip_ready_low,
	output var  logic       cs_n_pin,
	output var  logic [7:0] strobes
);
	int err; // ready waits that ran out
	// idle pins at time zero; serial clock and input are not modelled
	initial begin
		cs_n_pin = 1'h1;
		strobes  = 8'h00;
		err      = 0;
	end
	// one strobe, high across exactly one rising edge
	task automatic pulse(input int idx);
		@(negedge clk);
		strobes[idx] = 1'h1;
		@(negedge clk);
		strobes = 8'h00;
	endtask : pulse
	// bounded wait for the ready output to reach a level
	task automatic wait_ready(input logic lvl);
		int k;
		k = 0;
		while (chip_ready_low !== lvl && k < 300) begin
			@(negedge clk);
			k++;
		end
		if (chip_ready_low !== lvl)
			err++;
	endtask : wait_ready
	// select level; after a fall nothing is sent until ready
	task automatic sel(input logic lvl);
		@(negedge clk);
		cs_n_pin = lvl;
		if (!lvl)
			wait_ready(1'h0);
	endtask : sel
	// first power-up: select pulse held high past 40 us, then soft reset
	task automatic power_up();
		@(negedge clk);
		cs_n_pin = 1'h0;
		repeat (10) @(negedge clk);
		cs_n_pin = 1'h1;
		repeat (400) @(negedge clk);
		sel(1'h0);
		pulse(0);
		wait_ready(1'h1);
		wait_ready(1'h0);
	endtask : power_up
endmodule : rsc_host
`default_nettype wire

/* rsc_pkg.sv */
// shared constants and types of the radio state controller
package rsc_pkg;
	// ------------------------------------------------------------
	// controller states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		st_idle  = 7'h01,
		st_sleep = 7'h02,
		st_crystal_off_state  = 7'h04,
		st_cal   = 7'h08,
		st_synth = 7'h10,
		st_rx    = 7'h20,
		st_tx    = 7'h40
	} rsc_state_t;

	// ------------------------------------------------------------
	// field encodings
	// ------------------------------------------------------------
	localparam logic [1:0] DEST_IDLE     = 2'h0; // after rx/tx: idle
	localparam logic [1:0] DEST_SYNTH    = 2'h1; // after rx/tx: synth on
	localparam logic [1:0] DEST_TX       = 2'h2; // after rx/tx: transmit
	localparam logic [1:0] DEST_RX       = 2'h3; // after rx/tx: receive
	localparam logic [1:0] CAL_NEVER     = 2'h0; // no auto calibration
	localparam logic [1:0] CAL_FROM_IDLE = 2'h1; // idle to rx/tx/synth
	localparam logic [1:0] CAL_TO_IDLE   = 2'h2; // every auto return
	localparam logic [1:0] CAL_EVERY4    = 2'h3; // every fourth return
	localparam logic [1:0] CCA_ALWAYS    = 2'h0; // channel always clear
	localparam logic [1:0] CCA_RSSI      = 2'h1; // rssi below threshold
	localparam logic [1:0] CCA_NOPKT     = 2'h2; // no packet in progress
	localparam logic [1:0] CCA_BOTH      = 2'h3; // both of the above

	// ------------------------------------------------------------
	// counts and reset values
	// ------------------------------------------------------------
	localparam int         CLK_HZ          = 10_000_000; // crystal clock
	localparam int         GDO_DIV         = 192;        // clock out divide
	localparam logic [6:0] GDO_HALF_M1     = 7'(GDO_DIV / 2 - 1);
	localparam int         CAL_XOSC_CYCLES = 18815;      // synth calibration
	localparam int         RESET_STROBE_CYCLES     = 8;          // soft reset busy time
	localparam int         RSSI_CYCLES     = 16;         // rssi settle time
	localparam int         TMR_W           = 16;         // timer width
	localparam logic [1:0] AUTO_CNT_RST    = 2'h0;       // return counter reset
endpackage : rsc_pkg

/* rsc_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	// ------------------------------------------------------------
	// synchroniser stages
	// ------------------------------------------------------------
	logic [W-1:0] meta; // first stage, read only by q

	// both stages on the same edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= RST;
			q    <= RST;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : rsc_sync
`default_nettype wire

/* rsc_timer.sv */
// loadable down-counting timer
`timescale 1ns/1ps
`default_nettype none
module rsc_timer #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         clear,
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	output var  logic         busy,
	output var  logic         done
);
	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	logic [W-1:0] cnt; // cycles left

	// clear wins, then start, then count down
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
		end else if (clear) begin
			cnt <= '0;
		end else if (start) begin
			cnt <= load;
		end else if (cnt != '0) begin
			cnt <= cnt - W'(1);
		end
	end

	// done marks the last counted cycle
	always_comb begin
		busy = (cnt != '0);
		done = (cnt == W'(1)) && !clear;
	end
endmodule : rsc_timer
`default_nettype wire
